// >>> hw/orx_consts.svh
// orx_consts.svh: constants for the or / return / rotate-left execution unit
// assumes it is included by bare name from the package and the design file
//
// Overview of operation
// RULE_01: or immediate into working register, zero flag only
// RULE_02: or working register into memory byte, zero only
// RULE_03: subroutine exit reloads pc from stack top
// RULE_04: literal exit reloads pc and loads working register
// RULE_05: interrupt exit reloads pc, sets interrupt enable
// RULE_06: pending interrupt serviced before resuming main program
// RULE_07: rotate memory byte left in place, no flags
// RULE_08: rotated memory byte goes to working register only
// RULE_09: zero flag set when eight-bit result is zero
`ifndef ORX_CONSTS_SVH
`define ORX_CONSTS_SVH

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define ORX_DATA_W 8
`define ORX_PC_W 12
`define ORX_ADDR_W 8
`define ORX_STACK_DEPTH 4
`define ORX_SP_W 2
`define ORX_RESET_PC 12'h000
`define ORX_RESET_WREG 8'h00
`define ORX_INT_VECTOR 12'h004

`endif

// >>> hw/orx_pkg.sv
// orx_pkg.sv: types of the or / return / rotate-left execution unit
// assumes orx_consts.svh is on the include path
`include "orx_consts.svh"

package orx_pkg;

    // ----------------------------------------------------------------
    // operation selector given with each executed instruction
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ORX_OP_NONE = 4'h0,
        ORX_OP_OR_IMM = 4'h1,
        ORX_OP_OR_MEM = 4'h2,
        ORX_OP_EXIT = 4'h3,
        ORX_OP_EXIT_LIT = 4'h4,
        ORX_OP_INT_EXIT = 4'h5,
        ORX_OP_ROT_MEM = 4'h6,
        ORX_OP_ROT_WREG = 4'h7,
        ORX_OP_CALL = 4'h8
    } orx_op_t;

    // ----------------------------------------------------------------
    // sequencer states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ORX_ST_RUN = 2'b01,
        ORX_ST_ENTER = 2'b10
    } orx_state_t;

endpackage

// >>> hw/orx_exec.sv
// orx_exec.sv: execution of or, subroutine/interrupt exit and rotate left
// assumes one instruction per i_valid pulse; memory byte is presented on
// i_mem_rdata for the addressed location in the same cycle
`include "orx_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module orx_exec (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_valid,
    input wire logic [3:0] i_op,
    input wire logic [`ORX_DATA_W-1:0] i_literal,
    input wire logic [`ORX_DATA_W-1:0] i_mem_rdata,
    input wire logic [`ORX_ADDR_W-1:0] i_mem_addr,
    input wire logic [`ORX_PC_W-1:0] i_call_target,
    input wire logic i_int_pending,
    output logic [`ORX_PC_W-1:0] o_pc,
    output logic [`ORX_DATA_W-1:0] o_working_register,
    output logic o_zero_flag,
    output logic o_master_interrupt_enable,
    output logic o_mem_we,
    output logic [`ORX_ADDR_W-1:0] o_mem_addr,
    output logic [`ORX_DATA_W-1:0] o_mem_wdata,
    output logic o_int_taken
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // left rotate with bit 7 wrapping into bit 0
    function automatic logic [`ORX_DATA_W-1:0] rot_left(
        input logic [`ORX_DATA_W-1:0] v);
        rot_left = {v[`ORX_DATA_W-2:0], v[`ORX_DATA_W-1]};
    endfunction

    // zero detect on an eight-bit result
    function automatic logic is_zero(input logic [`ORX_DATA_W-1:0] v);
        is_zero = (v == 8'h00);
    endfunction

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    orx_pkg::orx_op_t op; // decoded operation
    orx_pkg::orx_state_t state_reg; // sequencer state
    logic run; // an instruction executes this cycle
    logic is_exit; // any of the three exits
    logic [`ORX_DATA_W-1:0] or_imm; // or with literal
    logic [`ORX_DATA_W-1:0] or_mem; // or with memory byte
    logic [`ORX_DATA_W-1:0] rot; // rotated memory byte
    logic [`ORX_DATA_W-1:0] wreg_reg; // working register
    logic [`ORX_PC_W-1:0] pc_reg; // program counter
    logic mie_reg; // master interrupt enable
    logic [`ORX_PC_W-1:0] stack_reg [`ORX_STACK_DEPTH]; // return stack
    logic [`ORX_SP_W-1:0] sp_reg; // next free stack slot
    logic [`ORX_SP_W-1:0] top; // index of stack top

    assign op = orx_pkg::orx_op_t'(i_op);
    assign run = i_valid && (state_reg == orx_pkg::ORX_ST_RUN);
    assign is_exit = (op == orx_pkg::ORX_OP_EXIT) ||
        (op == orx_pkg::ORX_OP_EXIT_LIT) || (op == orx_pkg::ORX_OP_INT_EXIT);
    assign or_imm = wreg_reg | i_literal;
    assign or_mem = wreg_reg | i_mem_rdata;
    assign rot = rot_left(i_mem_rdata);
    assign top = sp_reg - 2'b01;

    // ----------------------------------------------------------------
    // sequencer: pending interrupt after interrupt exit is entered
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_reg <= orx_pkg::ORX_ST_RUN;
        end else begin
            unique case (state_reg)
                orx_pkg::ORX_ST_RUN: begin
                    // re-enabled and a request waits: take it first
                    if (run && op == orx_pkg::ORX_OP_INT_EXIT &&
                        i_int_pending) begin // [RULE_06]
                        state_reg <= orx_pkg::ORX_ST_ENTER;
                    end
                end
                orx_pkg::ORX_ST_ENTER: begin
                    state_reg <= orx_pkg::ORX_ST_RUN;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // program counter and return stack
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pc_reg <= `ORX_RESET_PC;
            sp_reg <= '0;
            for (int i = 0; i < `ORX_STACK_DEPTH; i++) begin
                stack_reg[i] <= `ORX_RESET_PC;
            end
        end else if (state_reg == orx_pkg::ORX_ST_ENTER) begin
            // push the restored address, jump to the service vector
            stack_reg[sp_reg] <= pc_reg; // [RULE_06]
            sp_reg <= sp_reg + 2'b01;
            pc_reg <= `ORX_INT_VECTOR;
        end else if (run && is_exit) begin
            // all exits pop the stack top into pc
            pc_reg <= stack_reg[top]; // [RULE_03] [RULE_04] [RULE_05]
            sp_reg <= top;
        end else if (run && op == orx_pkg::ORX_OP_CALL) begin
            // call pushes the return address
            stack_reg[sp_reg] <= pc_reg + 12'h001;
            sp_reg <= sp_reg + 2'b01;
            pc_reg <= i_call_target;
        end else if (run && op != orx_pkg::ORX_OP_NONE) begin
            pc_reg <= pc_reg + 12'h001;
        end
    end

    // ----------------------------------------------------------------
    // working register and zero flag
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            wreg_reg <= `ORX_RESET_WREG;
            o_zero_flag <= 1'b0;
        end else if (run) begin
            unique case (op)
                orx_pkg::ORX_OP_OR_IMM: begin
                    wreg_reg <= or_imm; // [RULE_01]
                    o_zero_flag <= is_zero(or_imm); // [RULE_09]
                end
                orx_pkg::ORX_OP_OR_MEM: begin
                    o_zero_flag <= is_zero(or_mem); // [RULE_02] [RULE_09]
                end
                orx_pkg::ORX_OP_EXIT_LIT: begin
                    wreg_reg <= i_literal; // [RULE_04]
                end
                orx_pkg::ORX_OP_ROT_WREG: begin
                    wreg_reg <= rot; // [RULE_08]
                end
                default: begin
                    // other operations leave register and flag alone
                end
            endcase
        end
    end
    assign o_working_register = wreg_reg;

    // ----------------------------------------------------------------
    // master interrupt enable
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            mie_reg <= 1'b0;
        end else if (state_reg == orx_pkg::ORX_ST_ENTER) begin
            mie_reg <= 1'b0; // entering service masks further requests
        end else if (run && op == orx_pkg::ORX_OP_INT_EXIT) begin
            mie_reg <= 1'b1; // [RULE_05]
        end
    end

    // ----------------------------------------------------------------
    // memory write port and interrupt entry pulse
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_mem_we <= 1'b0;
            o_mem_addr <= '0;
            o_mem_wdata <= '0;
            o_int_taken <= 1'b0;
        end else begin
            o_mem_addr <= i_mem_addr;
            o_int_taken <= (state_reg == orx_pkg::ORX_ST_ENTER);
            if (run && op == orx_pkg::ORX_OP_OR_MEM) begin
                o_mem_we <= 1'b1;
                o_mem_wdata <= or_mem; // [RULE_02]
            end else if (run && op == orx_pkg::ORX_OP_ROT_MEM) begin
                o_mem_we <= 1'b1;
                o_mem_wdata <= rot; // [RULE_07]
            end else begin
                o_mem_we <= 1'b0; // rotate to working leaves memory [RULE_08]
            end
        end
    end

    assign o_pc = pc_reg;
    assign o_master_interrupt_enable = mie_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_or_imm_result: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_01]
        run && op == orx_pkg::ORX_OP_OR_IMM |=>
        o_working_register == ($past(wreg_reg) | $past(i_literal)))
        else $error("or immediate result wrong");
    a_or_mem_write: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_02]
        run && op == orx_pkg::ORX_OP_OR_MEM |=> o_mem_we &&
        o_mem_wdata == ($past(wreg_reg) | $past(i_mem_rdata)))
        else $error("or into memory write wrong");
    a_exit_pops_pc: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_03]
        run && op == orx_pkg::ORX_OP_EXIT |=>
        o_pc == $past(stack_reg[top]) && $stable(o_zero_flag))
        else $error("subroutine exit pc wrong");
    a_exit_literal: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_04]
        run && op == orx_pkg::ORX_OP_EXIT_LIT |=>
        o_working_register == $past(i_literal) && $stable(o_zero_flag))
        else $error("literal exit did not load working register");
    a_int_exit_mie: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_05]
        run && op == orx_pkg::ORX_OP_INT_EXIT && !i_int_pending |=>
        o_master_interrupt_enable)
        else $error("interrupt exit did not enable interrupts");
    a_pending_entry: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_06]
        run && op == orx_pkg::ORX_OP_INT_EXIT && i_int_pending |=>
        ##1 o_int_taken && o_pc == `ORX_INT_VECTOR)
        else $error("pending interrupt not entered");
    a_rot_in_place: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_07]
        run && op == orx_pkg::ORX_OP_ROT_MEM |=> o_mem_we &&
        o_mem_wdata == rot_left($past(i_mem_rdata)) && $stable(o_zero_flag))
        else $error("rotate in place wrong");
    a_rot_to_wreg: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_08]
        run && op == orx_pkg::ORX_OP_ROT_WREG |=> !o_mem_we &&
        o_working_register == rot_left($past(i_mem_rdata)))
        else $error("rotate to working register wrong");
    a_zero_flag: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_09]
        run && op == orx_pkg::ORX_OP_OR_IMM |=>
        o_zero_flag == (o_working_register == 8'h00))
        else $error("zero flag wrong");

    c_or_mem_zero: cover property (@(posedge i_sys_clk)
        run && op == orx_pkg::ORX_OP_OR_MEM && or_mem == 8'h00);
    c_int_exit_pending: cover property (@(posedge i_sys_clk)
        run && op == orx_pkg::ORX_OP_INT_EXIT && i_int_pending);
    c_rot_wrap: cover property (@(posedge i_sys_clk)
        run && op == orx_pkg::ORX_OP_ROT_MEM && i_mem_rdata[7]);

endmodule

`default_nettype wire

// >>> verif/or_return_rotate_left_exec_bench.sv
// or_return_rotate_left_exec_bench.sv: directed bench for orx_exec
// assumes orx_consts.svh on the include path and orx_pkg compiled first
`include "orx_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module or_return_rotate_left_exec_bench;
    // ----------------------------------------------------------------
    // clock, stimulus and observed signals
    // ----------------------------------------------------------------
    logic i_sys_clk = 1'b0; // 20 mhz system clock
    logic i_reset = 1'b1; // synchronous reset, active high
    logic i_valid = 1'b0; // instruction present
    logic [3:0] i_op = 4'h0; // operation code
    logic [7:0] i_literal = 8'h00; // immediate operand
    logic [7:0] i_mem_rdata = 8'h00; // addressed memory byte
    logic [7:0] i_mem_addr = 8'h00; // memory address
    logic [11:0] i_call_target = 12'h000; // call destination
    logic i_int_pending = 1'b0; // interrupt request pending
    logic [11:0] o_pc;
    logic [7:0] o_working_register;
    logic o_zero_flag;
    logic o_master_interrupt_enable;
    logic o_mem_we;
    logic [7:0] o_mem_addr;
    logic [7:0] o_mem_wdata;
    logic o_int_taken;
    int failures = 0; // mismatches seen
    int check_count = 0; // comparisons made
    logic [11:0] ret_pc; // expected return address

    orx_exec uut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .i_valid(i_valid), .i_op(i_op), .i_literal(i_literal),
        .i_mem_rdata(i_mem_rdata), .i_mem_addr(i_mem_addr),
        .i_call_target(i_call_target), .i_int_pending(i_int_pending),
        .o_pc(o_pc), .o_working_register(o_working_register),
        .o_zero_flag(o_zero_flag),
        .o_master_interrupt_enable(o_master_interrupt_enable),
        .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .o_int_taken(o_int_taken));

    // 50 ns period
    initial begin
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    // compare one observed value with its expectation
    task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what,
                     got, exp);
        end
    endtask

    // present one instruction for one edge; returns with results settled
    // an idle edge goes first so that no request line is lowered and
    // raised again within one time step
    task automatic issue(input logic [3:0] op, input logic [7:0] lit,
                         input logic [7:0] rd, input logic [7:0] ad);
        @(negedge i_sys_clk);
        i_valid = 1'b1;
        i_op = op;
        i_literal = lit;
        i_mem_rdata = rd;
        i_mem_addr = ad;
        @(negedge i_sys_clk);
        i_valid = 1'b0;
        i_op = 4'h0;
        i_mem_rdata = ~rd; // stale byte must not be reused
    endtask

    // call a subroutine and remember where it must come back to
    task automatic do_call(input logic [11:0] tgt);
        ret_pc = o_pc + 12'h001;
        i_call_target = tgt;
        issue(orx_pkg::ORX_OP_CALL, 8'h00, 8'h00, 8'h00);
        chk(o_pc, tgt, "call target");
    endtask

    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // or immediate: zero result, then nonzero result
    task automatic test_or_imm();
        issue(orx_pkg::ORX_OP_OR_IMM, 8'h00, 8'h00, 8'h00);
        chk(o_working_register, 8'h00, "or imm zero");
        chk(o_zero_flag, 1'b1, "zero set");
        issue(orx_pkg::ORX_OP_OR_IMM, 8'h81, 8'h00, 8'h00);
        chk(o_working_register, 8'h81, "or imm");
        chk(o_zero_flag, 1'b0, "zero clear");
        chk(o_mem_we, 1'b0, "no write");
        $display("test or immediate done");
    endtask

    // rotate to working register, memory untouched
    task automatic test_rot_wreg();
        issue(orx_pkg::ORX_OP_ROT_WREG, 8'h00, 8'h81, 8'h22);
        chk(o_working_register, 8'h03, "rot to wreg");
        chk(o_mem_we, 1'b0, "rot wreg no write");
        chk(o_zero_flag, 1'b0, "rot wreg flag");
        $display("test rotate to working done");
    endtask

    // or into memory, then in-place rotate with working register left alone
    task automatic test_mem_ops();
        issue(orx_pkg::ORX_OP_OR_MEM, 8'h00, 8'h40, 8'h5a);
        chk(o_mem_we, 1'b1, "or mem write");
        chk(o_mem_addr, 8'h5a, "or mem addr");
        chk(o_mem_wdata, 8'h43, "or mem data");
        chk(o_zero_flag, 1'b0, "or mem zero");
        chk(o_working_register, 8'h03, "or mem wreg");
        issue(orx_pkg::ORX_OP_OR_IMM, 8'h00, 8'h00, 8'h00);
        chk(o_mem_we, 1'b0, "write one cycle");
        i_literal = 8'h00;
        issue(orx_pkg::ORX_OP_ROT_MEM, 8'h00, 8'h80, 8'ha5);
        chk(o_mem_we, 1'b1, "rot mem write");
        chk(o_mem_addr, 8'ha5, "rot mem addr");
        chk(o_mem_wdata, 8'h01, "rot mem data");
        chk(o_working_register, 8'h03, "rot mem wreg");
        $display("test memory ops done");
    endtask

    // plain exit and exit with literal, flags unchanged
    task automatic test_exits();
        do_call(12'h123);
        issue(orx_pkg::ORX_OP_EXIT, 8'hff, 8'h00, 8'h00);
        chk(o_pc, ret_pc, "exit pc");
        chk(o_working_register, 8'h03, "exit wreg");
        do_call(12'h3f0);
        issue(orx_pkg::ORX_OP_EXIT_LIT, 8'h00, 8'h00, 8'h00);
        chk(o_pc, ret_pc, "exit lit pc");
        chk(o_working_register, 8'h00, "exit lit wreg");
        chk(o_zero_flag, 1'b0, "exit lit flag");
        $display("test exits done");
    endtask

    // interrupt exit without and with a pending request
    task automatic test_int_exit();
        // zero result sets the flag so the exit must visibly keep it
        issue(orx_pkg::ORX_OP_OR_IMM, 8'h00, 8'h00, 8'h00);
        chk(o_zero_flag, 1'b1, "zero before exit");
        do_call(12'h200);
        issue(orx_pkg::ORX_OP_INT_EXIT, 8'h00, 8'h00, 8'h00);
        chk(o_pc, ret_pc, "int exit pc");
        chk(o_master_interrupt_enable, 1'b1, "mie set");
        chk(o_zero_flag, 1'b1, "int exit flag");
        do_call(12'h2c0);
        i_int_pending = 1'b1;
        issue(orx_pkg::ORX_OP_INT_EXIT, 8'h00, 8'h00, 8'h00);
        chk(o_pc, ret_pc, "pending exit pc");
        chk(o_master_interrupt_enable, 1'b1, "pending mie");
        @(negedge i_sys_clk);
        i_int_pending = 1'b0;
        chk(o_pc, `ORX_INT_VECTOR, "service entry");
        chk(o_int_taken, 1'b1, "entry pulse");
        chk(o_master_interrupt_enable, 1'b0, "service masked");
        @(negedge i_sys_clk);
        chk(o_int_taken, 1'b0, "entry pulse ends");
        issue(orx_pkg::ORX_OP_EXIT, 8'h00, 8'h00, 8'h00);
        chk(o_pc, ret_pc, "back to main");
        $display("test interrupt exit done");
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_reset = 1'b0;
        chk(o_pc, `ORX_RESET_PC, "reset pc");
        chk(o_working_register, `ORX_RESET_WREG, "reset wreg");
        test_or_imm();
        test_rot_wreg();
        test_mem_ops();
        test_exits();
        test_int_exit();
        close_out();
    end

    // a hang counts as a mismatch
    initial begin
        #100000;
        failures++;
        $display("ERROR at %0t: run did not finish", $time);
        close_out();
    end
endmodule

`default_nettype wire
